// ---- core/ddpc_core.sv ----
// command core of a dual 1024-position digital potentiometer
// assumes an external pull-up on both open-drain outputs
`timescale 1ns/10ps
`default_nettype none
module ddpc_core
  import ddpc_pkg::*;
#(
  parameter int unsigned STORE_CYCLES_P = STORE_CYCLES
)(
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               arst_n,
  // serial link
  input  wire logic               link_sclk,
  input  wire logic               link_cs_n,
  input  wire logic               link_sdi,
  output logic                    sdo_out,
  output logic                    sdo_oe,
  // control pins
  input  wire logic               preset_strobe_n,
  input  wire logic               write_protect_n,
  // completion
  output logic                    rdy_out,
  output logic                    rdy_oe,
  // wiper setting registers
  output logic [WIPER_W-1:0]      wiper0_setting,
  output logic [WIPER_W-1:0]      wiper1_setting
);

  localparam logic [TIMER_W-1:0] STORE_LAST = TIMER_W'(STORE_CYCLES_P - 1);
  localparam logic [TIMER_W-1:0] RDY_LAST   = TIMER_W'(RDY_PULSE_CYCLES - 1);
  localparam logic [CNT_W-1:0]   BIT_LAST   = CNT_W'(FRAME_BITS - 1);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [WIPER_W-1:0] adjust(input logic [WIPER_W-1:0] w,
                                                input logic [3:0]         op);
    logic [WIPER_W-1:0] r;
    r = w;
    case ({op[3], op[1]})
      2'b00:   r = w >> 1;
      2'b01:   r = (w == WIPER_MIN) ? WIPER_MIN : w - 10'h001;
      2'b10:   r = w[WIPER_W-1] ? WIPER_MAX : {w[WIPER_W-2:0], 1'b0};
      default: r = (w == WIPER_MAX) ? WIPER_MAX : w + 10'h001;
    endcase
    return r;  // see R24
  endfunction

  // ----------------------------------------
  // link domain
  // ----------------------------------------
  logic                  first_reg;
  logic [CNT_W-1:0]      cnt_reg;
  logic [CNT_W-1:0]      cnt_next;
  logic                  tog_reg;
  logic [FRAME_BITS-1:0] rx_sh_reg;
  logic [CNT_W-1:0]      tx_idx_reg;
  logic [FRAME_BITS-1:0] tx_word_reg;
  logic                  sdo_bit;

  assign cnt_next = first_reg ? CNT_W'(1) :
                    (cnt_reg == BIT_LAST) ? CNT_W'(0) : cnt_reg + CNT_W'(1);  // see R23

  always_ff @(posedge link_sclk or posedge link_cs_n) begin
    if (link_cs_n) begin
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
    end
  end

  always_ff @(posedge link_sclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg   <= 5'h00;
      tog_reg   <= 1'b0;
      rx_sh_reg <= 24'h000000;
    end else if (!link_cs_n) begin
      rx_sh_reg <= {rx_sh_reg[FRAME_BITS-2:0], link_sdi};  // see R1 see R22
      cnt_reg   <= cnt_next;
      tog_reg   <= tog_reg ^ first_reg;
    end
  end

  always_ff @(negedge link_sclk or posedge link_cs_n) begin
    if (link_cs_n) begin
      tx_idx_reg <= 5'h00;
    end else if (tx_idx_reg != CNT_W'(FRAME_BITS)) begin
      tx_idx_reg <= tx_idx_reg + CNT_W'(1);
    end
  end

  // past one frame the received bits pass on for daisy chains
  assign sdo_bit = (tx_idx_reg == CNT_W'(FRAME_BITS)) ? rx_sh_reg[FRAME_BITS-1] :
                   tx_word_reg[BIT_LAST - tx_idx_reg];  // see R10
  assign sdo_oe  = ~link_cs_n & ~sdo_bit;  // see R18 see R19
  assign sdo_out = 1'b0;

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  logic cs_s1_reg, cs_s2_reg, cs_prev_reg;
  logic pr_s1_reg, pr_s2_reg, pr_prev_reg;
  logic wp_s1_reg, wp_s2_reg;
  logic tog_s1_reg, tog_s2_reg, tog_seen_reg;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      {cs_s1_reg, cs_s2_reg, cs_prev_reg}    <= 3'h7;
      {pr_s1_reg, pr_s2_reg, pr_prev_reg}    <= 3'h7;
      {wp_s1_reg, wp_s2_reg}                 <= 2'h3;
      {tog_s1_reg, tog_s2_reg, tog_seen_reg} <= 3'h0;
    end else begin
      {cs_s1_reg, cs_s2_reg, cs_prev_reg} <= {link_cs_n, cs_s1_reg, cs_s2_reg};
      {pr_s1_reg, pr_s2_reg, pr_prev_reg} <= {preset_strobe_n, pr_s1_reg, pr_s2_reg};
      {wp_s1_reg, wp_s2_reg}              <= {write_protect_n, wp_s1_reg};
      tog_s1_reg <= tog_reg;
      tog_s2_reg <= tog_s1_reg;
      if (cs_s2_reg && !cs_prev_reg) begin
        tog_seen_reg <= tog_s2_reg;
      end
    end
  end

  // ----------------------------------------
  // frame decode
  // ----------------------------------------
  ddpc_state_type        state_reg, state_next;
  logic [FRAME_BITS-1:0] last_word_reg, last_word_next;
  logic                  have_last_reg, have_last_next;
  logic [FRAME_BITS-1:0] tx_word_next;
  logic                  pr_pend_reg;
  logic [WIPER_W-1:0]    wiper_reg [2];
  logic [WIPER_W-1:0]    wiper_next [2];

  wire                  cs_rise    = cs_s2_reg & ~cs_prev_reg;
  wire                  new_frame  = tog_s2_reg ^ tog_seen_reg;
  wire [FRAME_BITS-1:0] exec_word  = new_frame ? rx_sh_reg : last_word_reg;
  wire                  frame_ok   = new_frame ? (cnt_reg == 5'h00) : have_last_reg;  // see R23
  wire                  wp_on      = ~wp_s2_reg;
  wire                  pr_low     = ~pr_s2_reg;
  wire                  pr_rise    = pr_s2_reg & ~pr_prev_reg;
  wire                  exec       = cs_rise & frame_ok & ~pr_low
                                     & (state_reg == S_IDLE);  // see R20 see R3
  wire [3:0]            cmd        = exec_word[CMD_POS+3:CMD_POS];
  wire [3:0]            addr       = exec_word[ADDR_POS+3:ADDR_POS];
  wire [DATA_W-1:0]     data       = exec_word[DATA_W-1:0];
  wire                  ch         = addr[0];  // see R11
  wire                  adj_ok     = exec & cmd[2] & ~wp_on;  // see R16
  wire                  all_ch     = cmd[0];  // see R25
  wire                  wr_ok      = exec & (cmd == CMD_WRITE) & ~wp_on;  // see R8 see R16

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  logic [3:0]           op_reg, op_next;
  logic [1:0]           mask_reg, mask_next;
  logic                 phase_reg, phase_next;
  logic                 rdy_req_reg, rdy_req_next;
  logic [NV_ADDR_W-1:0] rd_addr_reg, rd_addr_next;
  logic [NV_ADDR_W-1:0] wr_addr_reg, wr_addr_next;
  logic [DATA_W-1:0]    wr_data_reg, wr_data_next;
  logic [TIMER_W-1:0]   timer_reg, timer_next;
  logic                 pr_take;
  logic [DATA_W-1:0]    nv_rd_data;

  wire store_done = (state_reg == S_STORE) & (timer_reg == STORE_LAST);
  wire nv_wr_en   = store_done;  // see R9

  always_comb begin
    state_next     = state_reg;
    op_next        = op_reg;
    mask_next      = mask_reg;
    phase_next     = phase_reg;
    rdy_req_next   = rdy_req_reg;
    rd_addr_next   = rd_addr_reg;
    wr_addr_next   = wr_addr_reg;
    wr_data_next   = wr_data_reg;
    timer_next     = 22'h000000;
    tx_word_next   = tx_word_reg;
    last_word_next = last_word_reg;
    have_last_next = have_last_reg;
    pr_take        = 1'b0;
    case (state_reg)
      S_IDLE: begin
        if (pr_pend_reg && !pr_low) begin
          pr_take      = 1'b1;
          op_next      = CMD_RESET;
          {mask_next, phase_next, rd_addr_next, rdy_req_next} = {2'b11, 1'b0, 4'h0, 1'b1};
          state_next   = S_WAIT;  // see R15 see R21
        end else if (exec) begin
          tx_word_next   = exec_word;  // see R10
          last_word_next = exec_word;
          have_last_next = 1'b1;
          op_next        = cmd;
          case (cmd)
            CMD_RESTORE: begin
              mask_next    = ch ? 2'b10 : 2'b01;
              phase_next   = ch;
              rd_addr_next = {3'h0, ch};
              rdy_req_next = 1'b0;
              state_next   = S_WAIT;  // see R13
            end
            CMD_RESET: begin
              {mask_next, phase_next, rd_addr_next, rdy_req_next} = {2'b11, 1'b0, 4'h0, 1'b1};
              state_next   = S_WAIT;  // see R14
            end
            CMD_READ_NV: begin
              rd_addr_next = addr;
              mask_next    = 2'b00;
              state_next   = S_WAIT;  // see R21
            end
            CMD_READ_WIPER: begin
              tx_word_next[DATA_W-1:0] = {6'h00, wiper_reg[ch]};
              state_next = S_RDY;  // see R21
            end
            CMD_STORE_SET: begin
              if (!wp_on) begin
                wr_addr_next = {3'h0, ch};
                wr_data_next = {6'h00, wiper_reg[ch]};
                state_next   = S_STORE;  // see R9 see R16
              end
            end
            CMD_STORE_ANY: begin
              if (!wp_on && addr != NV_RESERVED) begin
                wr_addr_next = addr;
                wr_data_next = data;
                state_next   = S_STORE;  // see R5 see R16
              end
            end
            default: begin
              state_next = S_IDLE;
            end
          endcase
        end
      end
      S_WAIT: begin
        state_next = S_TAKE;
      end
      S_TAKE: begin
        if (op_reg == CMD_READ_NV) begin
          tx_word_next[DATA_W-1:0] = nv_rd_data;
          state_next = S_RDY;
        end else if (!phase_reg && mask_reg[1]) begin
          phase_next   = 1'b1;
          rd_addr_next = 4'h1;
          state_next   = S_WAIT;
        end else begin
          state_next = rdy_req_reg ? S_RDY : S_IDLE;
        end
      end
      S_STORE: begin
        timer_next = timer_reg + 22'h000001;
        if (store_done) begin
          timer_next = 22'h000000;
          state_next = S_RDY;  // see R3 see R4
        end
      end
      S_RDY: begin
        timer_next = timer_reg + 22'h000001;
        if (timer_reg == RDY_LAST) begin
          timer_next = 22'h000000;
          state_next = S_IDLE;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // wiper setting registers
  // ----------------------------------------
  wire restore_take = (state_reg == S_TAKE) & (op_reg != CMD_READ_NV);

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      wiper_next[i] = wiper_reg[i];
      if (pr_low) begin
        wiper_next[i] = WIPER_MID;  // see R15
      end else if (restore_take && phase_reg == i[0] && mask_reg[i]) begin
        wiper_next[i] = nv_rd_data[WIPER_W-1:0];  // see R12 see R13 see R14
      end else if (adj_ok && (all_ch || ch == i[0])) begin
        wiper_next[i] = adjust(wiper_reg[i], cmd);  // see R6 see R24 see R25
      end else if (wr_ok && ch == i[0]) begin
        wiper_next[i] = data[WIPER_W-1:0];  // see R8 see R11
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg     <= S_WAIT;  // see R12
      op_reg        <= CMD_RESET;
      mask_reg      <= 2'b11;
      phase_reg     <= 1'b0;
      rdy_req_reg   <= 1'b0;
      rd_addr_reg   <= 4'h0;
      wr_addr_reg   <= 4'h0;
      wr_data_reg   <= 16'h0000;
      timer_reg     <= 22'h000000;
      tx_word_reg   <= 24'h000000;
      last_word_reg <= 24'h000000;
      have_last_reg <= 1'b0;
      pr_pend_reg   <= 1'b0;
      rdy_oe        <= 1'b0;
      wiper_reg[0]  <= WIPER_MIN;  // see R7
      wiper_reg[1]  <= WIPER_MIN;
    end else begin
      state_reg     <= state_next;
      op_reg        <= op_next;
      mask_reg      <= mask_next;
      phase_reg     <= phase_next;
      rdy_req_reg   <= rdy_req_next;
      rd_addr_reg   <= rd_addr_next;
      wr_addr_reg   <= wr_addr_next;
      wr_data_reg   <= wr_data_next;
      timer_reg     <= timer_next;
      tx_word_reg   <= tx_word_next;
      last_word_reg <= last_word_next;
      have_last_reg <= have_last_next;
      pr_pend_reg   <= pr_rise | (pr_pend_reg & ~pr_take);
      rdy_oe        <= (state_next == S_RDY);  // see R4 see R21
      wiper_reg[0]  <= wiper_next[0];  // see R2
      wiper_reg[1]  <= wiper_next[1];
    end
  end

  assign wiper0_setting = wiper_reg[0];
  assign wiper1_setting = wiper_reg[1];
  assign rdy_out        = 1'b0;  // see R19

  ddpc_nvmem ddpc_nvmem_inst (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .wr_en   (nv_wr_en),
    .wr_addr (wr_addr_reg),
    .wr_data (wr_data_reg),
    .rd_addr (rd_addr_reg),
    .rd_data (nv_rd_data)
  );

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence seq_store_end;
    (state_reg == S_STORE) && (timer_reg == STORE_LAST);
  endsequence
  sequence seq_rdy_pulse;
    rdy_oe [*8];
  endsequence

  a_store_lock: assert property ((state_reg == S_STORE) |=> $stable(wiper_reg[0])  // see R3
    || pr_low) else $error("wiper moved during store");
  a_store_rdy: assert property (seq_store_end |=> seq_rdy_pulse)  // see R4
    else $error("no completion pulse after store");
  a_write_wiper: assert property (wr_ok && !ch |=> wiper_reg[0] == $past(data[9:0]))  // see R8
    else $error("wiper 0 write lost");
  a_protect_hold: assert property (exec && wp_on && cmd[2] |=> $stable(wiper_reg[1]))  // see R16
    else $error("protected wiper changed");
  a_preset_mid: assert property (pr_low |=> wiper0_setting == WIPER_MID  // see R15
    && wiper1_setting == WIPER_MID) else $error("preset not midscale");
  a_inc_sat: assert property (adj_ok && cmd[3] && cmd[1] && (all_ch || !ch)  // see R24
    && wiper_reg[0] == WIPER_MAX |=> wiper_reg[0] == WIPER_MAX) else $error("step up wrapped");
  a_sdo_release: assert property (link_cs_n |-> !sdo_oe)  // see R18
    else $error("serial output driven while deselected");
  a_echo_word: assert property (exec && cmd != CMD_READ_NV && cmd != CMD_READ_WIPER  // see R10
    |=> tx_word_reg == $past(exec_word)) else $error("echo word wrong");
  a_reset_rdy: assert property (exec && cmd == CMD_RESET |-> ##[3:8] rdy_oe)  // see R14
    else $error("restore of both channels did not complete");

endmodule
`default_nettype wire

// ---- core/ddpc_nvmem.sv ----
// nonvolatile word store of the dual wiper core, registered read data
// assumes one write port and one read port on the core clock
`timescale 1ns/10ps
`default_nettype none
module ddpc_nvmem
  import ddpc_pkg::*;
(
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 arst_n,
  // write side
  input  wire logic                 wr_en,
  input  wire logic [NV_ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0]    wr_data,
  // read side
  input  wire logic [NV_ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0]    rd_data
);

  logic [DATA_W-1:0] mem_reg [NV_DEPTH];

  // ----------------------------------------
  // storage, factory midscale in channel words
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NV_DEPTH; i++) begin
        mem_reg[i] <= (i < 2) ? {6'h00, WIPER_MID} : NV_USER_RST;  // see R12
      end
    end else if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;  // see R9 see R5
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= 16'h0000;
    end else begin
      rd_data <= mem_reg[rd_addr];
    end
  end

endmodule
`default_nettype wire

// ---- core/ddpc_pkg.sv ----
// constants, command codes and state type of the dual wiper command core
// assumes a 100 MHz core clock and a separate serial link clock
//
// Behaviour
// R1: frame is command, address, sixteen data bits
// R2: wiper follows its rewritable setting register
// R3: store lasts 25 ms, link locked
// R4: completion output pulses low after store
// R5: user words at addresses 2 to 14
// R6: sixteen command codes decoded, 0 to 15
// R7: zero setting puts wiper at B end
// R8: command 0xB loads addressed wiper setting
// R9: command 0x2 stores wiper into nonvolatile copy
// R10: previous frame echoed on serial output
// R11: address bit zero picks channel, linear code
// R12: power-on loads wipers from nonvolatile copies
// R13: command 0x1 restores addressed channel
// R14: command 0x8 restores both channels
// R15: preset low forces midscale, rise restores
// R16: write protect blocks all but restores; the code still runs reads 0x9, 0xA and the no-op under protect
// R17: host sends no-op before lifting protect
// R18: serial output released while select high
// R19: open-drain outputs only pull low
// R20: command runs when select returns high
// R21: completion also for 3, 8, 9, 10, preset
// R22: host shifts words most significant first
// R23: only whole 24-bit multiples execute
// R24: step and 6 dB saturate, no wrap
// R25: all-channel commands ignore the address
package ddpc_pkg;

  // ----------------------------------------
  // frame layout
  // ----------------------------------------
  localparam int FRAME_BITS = 24;
  localparam int CMD_POS    = 20;
  localparam int ADDR_POS   = 16;
  localparam int DATA_W     = 16;
  localparam int CNT_W      = 5;

  // ----------------------------------------
  // command codes
  // ----------------------------------------
  localparam logic [3:0] CMD_NOP        = 4'h0;
  localparam logic [3:0] CMD_RESTORE    = 4'h1;
  localparam logic [3:0] CMD_STORE_SET  = 4'h2;
  localparam logic [3:0] CMD_STORE_ANY  = 4'h3;
  localparam logic [3:0] CMD_DOWN_6DB   = 4'h4;
  localparam logic [3:0] CMD_DOWN_6DB_A = 4'h5;
  localparam logic [3:0] CMD_DEC        = 4'h6;
  localparam logic [3:0] CMD_DEC_A      = 4'h7;
  localparam logic [3:0] CMD_RESET      = 4'h8;
  localparam logic [3:0] CMD_READ_NV    = 4'h9;
  localparam logic [3:0] CMD_READ_WIPER = 4'hA;
  localparam logic [3:0] CMD_WRITE      = 4'hB;
  localparam logic [3:0] CMD_UP_6DB     = 4'hC;
  localparam logic [3:0] CMD_UP_6DB_A   = 4'hD;
  localparam logic [3:0] CMD_INC        = 4'hE;
  localparam logic [3:0] CMD_INC_A      = 4'hF;

  // ----------------------------------------
  // wiper and nonvolatile store
  // ----------------------------------------
  localparam int         WIPER_W      = 10;
  localparam logic [9:0] WIPER_MIN    = 10'h000;
  localparam logic [9:0] WIPER_MAX    = 10'h3FF;
  localparam logic [9:0] WIPER_MID    = 10'h200;
  localparam int         NV_ADDR_W    = 4;
  localparam int         NV_DEPTH     = 16;
  localparam logic [3:0] NV_USER_LAST = 4'hE;
  localparam logic [3:0] NV_RESERVED  = 4'hF;
  localparam logic [15:0] NV_USER_RST = 16'h0000;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ           = 100;
  localparam int STORE_TIME_MS     = 25;
  localparam int STORE_CYCLES      = STORE_TIME_MS * 1000 * CLK_MHZ;
  localparam int RDY_PULSE_NS      = 1000;
  localparam int RDY_PULSE_CYCLES  = RDY_PULSE_NS * CLK_MHZ / 1000;
  localparam int TIMER_W           = 22;

  // ----------------------------------------
  // control states
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_IDLE,
    S_WAIT,
    S_TAKE,
    S_STORE,
    S_RDY
  } ddpc_state_type;

endpackage

// ---- verif/ddpc_core_tb.sv ----
// self-checking bench of the dual wiper command core
// assumes the host model on the link and a short store time
`timescale 1ns/10ps
`default_nettype none
module ddpc_core_tb;
  import ddpc_pkg::*;
  localparam int STORE_P = 200;
  logic ref_clk, arst_n, preset_strobe_n, write_protect_n;
  logic link_sclk, link_cs_n, link_sdi;
  logic sdo_out, sdo_oe, rdy_out, rdy_oe;
  logic [WIPER_W-1:0] w0, w1;
  logic [23:0] rx;
  logic [43:0] steps [10];
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;

  ddpc_core #(.STORE_CYCLES_P(STORE_P)) ddpc_core_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .link_sclk(link_sclk),
    .link_cs_n(link_cs_n), .link_sdi(link_sdi), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .preset_strobe_n(preset_strobe_n),
    .write_protect_n(write_protect_n), .rdy_out(rdy_out), .rdy_oe(rdy_oe),
    .wiper0_setting(w0), .wiper1_setting(w1));
  ddpc_host_model ddpc_host_model_inst (
    .link_sclk(link_sclk), .link_cs_n(link_cs_n),
    .link_sdi(link_sdi), .sdo_oe(sdo_oe));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // compare, transfer and verdict tasks
  // ----------------------------------------
  task automatic chk_val(input string what, input logic [23:0] e, input logic [23:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_flag(input string what, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (rdy_oe !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk_flag("completion", 1'b1, rdy_oe);
    n = 0;
    while (rdy_oe === 1'b1 && n < 150) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk_val("completion length", 24'd100, 24'(n));
  endtask
  // mode 0 fixed settle, 1 wait completion, 2 short gap
  task automatic send(input logic [23:0] w, input int mode);
    ddpc_host_model_inst.xfer(w, rx);
    if (mode == 1) wait_done();
    else begin
      repeat ((mode == 0) ? 10 : 4) @(posedge ref_clk);
      #1;
    end
  endtask
  task automatic give_verdict();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_write_echo();
    chk_val("power-on wiper0", 24'h200, 24'(w0));
    chk_val("power-on wiper1", 24'h200, 24'(w1));
    send(24'hB00100, 0);
    chk_val("wiper0", 24'h100, 24'(w0));
    send(24'hB10200, 0);
    chk_val("echo", 24'hB00100, rx);
    chk_val("wiper1", 24'h200, 24'(w1));
    chk_flag("sdo released", 1'b0, sdo_oe);
    chk_flag("rdy value", 1'b0, rdy_out);
    chk_flag("sdo value", 1'b0, sdo_out);
  endtask
  task automatic t_store();
    send(24'h200000, 2);
    send(24'hB00055, 1);
    chk_val("locked wiper0", 24'h100, 24'(w0));
    send(24'hB003FF, 0);
    send(24'h100000, 0);
    chk_val("restored wiper0", 24'h100, 24'(w0));
    send(24'h900000, 1);
    send(24'h000000, 0);
    chk_val("store readback", 24'h900100, rx);
    send(24'h32ABCD, 1);
    send(24'h920000, 1);
    send(24'h000000, 0);
    chk_val("user word", 24'h92ABCD, rx);
  endtask
  task automatic t_steps();
    steps = '{{24'hB003FF, 10'h3FF, 10'h200}, {24'hE00000, 10'h3FF, 10'h200},
              {24'hC10000, 10'h3FF, 10'h3FF}, {24'h500000, 10'h1FF, 10'h1FF},
              {24'h710000, 10'h1FE, 10'h1FE}, {24'hB10000, 10'h1FE, 10'h000},
              {24'h610000, 10'h1FE, 10'h000}, {24'hF00000, 10'h1FF, 10'h001},
              {24'h400000, 10'h0FF, 10'h001}, {24'hD10000, 10'h1FE, 10'h002}};
    foreach (steps[i]) begin
      send(steps[i][43:20], 0);
      chk_val("step wiper0", 24'(steps[i][19:10]), 24'(w0));
      chk_val("step wiper1", 24'(steps[i][9:0]), 24'(w1));
    end
    ddpc_host_model_inst.pulse_cs();
    repeat (10) @(posedge ref_clk);
    #1 chk_val("repeat wiper0", 24'h3FC, 24'(w0));
    chk_val("repeat wiper1", 24'h004, 24'(w1));
    send(24'hA10000, 1);
    send(24'h000000, 0);
    chk_val("wiper readback", 24'hA10004, rx);
  endtask
  task automatic t_protect_preset();
    write_protect_n = 1'b0;
    send(24'hB00123, 0);
    chk_val("protected wiper0", 24'h3FC, 24'(w0));
    send(24'hF00000, 0);
    chk_val("protected wiper1", 24'h004, 24'(w1));
    send(24'h200000, 0);
    send(24'h800000, 1);
    chk_val("reset wiper0", 24'h100, 24'(w0));
    chk_val("reset wiper1", 24'h200, 24'(w1));
    send(24'h000000, 0);
    write_protect_n = 1'b1;
    send(24'hB00333, 0);
    preset_strobe_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1 chk_val("preset midscale", 24'h200, 24'(w0));
    preset_strobe_n = 1'b1;
    wait_done();
    chk_val("preset restore", 24'h100, 24'(w0));
  endtask

  initial begin
    arst_n = 1'b0;
    preset_strobe_n = 1'b1;
    write_protect_n = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1 t_write_echo();
    t_store();
    t_steps();
    t_protect_preset();
    give_verdict();
  end
endmodule
`default_nettype wire

// ---- verif/ddpc_host_model.sv ----
// serial host model for the dual wiper command core
// assumes a pull-up on the serial output wire, mode 0 timing
`timescale 1ns/10ps
`default_nettype none
module ddpc_host_model (
  // serial link
  output logic      link_sclk,
  output logic      link_cs_n,
  output logic      link_sdi,
  // open-drain serial output enable
  input  wire logic sdo_oe
);
  initial begin
    link_sclk = 1'b0;
    link_cs_n = 1'b1;
    link_sdi  = 1'b1;
  end

  // one whole frame, msb first, clock still outside frames
  task automatic xfer(input logic [23:0] w, output logic [23:0] rx);
    link_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      link_sdi = w[i];
      #6 link_sclk = 1'b1;
      rx[i] = ~sdo_oe;
      #6 link_sclk = 1'b0;
    end
    #6 link_cs_n = 1'b1;
    link_sdi = ~w[0];
  endtask

  // select pulse with no clock, repeats the last command
  task automatic pulse_cs();
    link_cs_n = 1'b0;
    #30 link_cs_n = 1'b1;
  endtask
endmodule
`default_nettype wire
